// ### gpevt_pkg.sv
// Shared constants, register map and carrier types for the event and
// general-purpose I/O register group.
// Assumes an 8-bit register port and five shared pins routed by 4-bit fields.
`default_nettype none

package gpevt_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS  = 8'h88;
  localparam logic [7:0] ADDR_ENABLE  = 8'h89;
  localparam logic [7:0] ADDR_INPUT   = 8'h8A;
  localparam logic [7:0] ADDR_OUTPUT  = 8'h8B;

  // Field positions inside the status and enable registers.
  localparam int unsigned BIT_POWER    = 7;
  localparam int unsigned BIT_HIGH_VPP = 6;
  localparam int unsigned BIT_RSVD     = 5;
  localparam int unsigned GP_MSB       = 4;
  localparam int unsigned NUM_GP       = 5;

  // Writable bit masks; everything outside reads back as zero.
  localparam logic [7:0] EVENT_MASK   = 8'hDF;
  localparam logic [7:0] GP_MASK      = 8'h1F;

  // Reset values.
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [4:0] OUTPUT_RST   = 5'h00;
  localparam logic [7:0] RDATA_IDLE   = 8'h00;

  // Routing field codes for a shared pin.
  localparam logic [3:0] ROUTE_INPUT  = 4'h0;
  localparam logic [3:0] ROUTE_OUTPUT = 4'h1;

  // Width of one socket's power state word.
  localparam int unsigned PWR_W       = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpevt_bus_req_t;

  typedef struct packed {
    logic [3:0] pin5;
    logic [3:0] pin4;
    logic [3:0] pin2;
    logic [3:0] pin1;
    logic [3:0] pin0;
  } gpevt_route_t;

  typedef struct packed {
    logic [PWR_W-1:0] state_a;
    logic [PWR_W-1:0] state_b;
    logic             vpp12_a;
    logic             vpp12_b;
  } gpevt_pwr_req_t;

  // Returns one bit per general line, line 4 first, set where the field holds code.
  function automatic logic [4:0] gpevt_route_match(input gpevt_route_t r,
                                                   input logic [3:0] code);
    gpevt_route_match = {r.pin5 == code, r.pin4 == code, r.pin2 == code,
                         r.pin1 == code, r.pin0 == code};
  endfunction : gpevt_route_match

endpackage : gpevt_pkg

`default_nettype wire

// ### gpevt_pin_mon.sv
// Level tracker and change detector for the five general input lines.
// Assumes pin levels are already synchronous to clk.
`default_nettype none

module gpevt_pin_mon (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [4:0] pin_in,
  input  wire logic [4:0] is_input,
  output logic      [4:0] level_q,
  output logic      [4:0] change
);
  import gpevt_pkg::*;

  logic primed_q;

  // The level is tracked even while a pin is routed elsewhere, so turning a
  // pin into an input later does not report a stale difference as an event.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      level_q <= OUTPUT_RST;
    end else begin
      level_q <= pin_in;
    end
  end

  // The first sample after reset only loads the tracker.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  assign change = (pin_in ^ level_q) & is_input & {NUM_GP{primed_q}};

endmodule : gpevt_pin_mon

`default_nettype wire

// ### gpevt_regs.sv
// Event status, event enable, input level and output level registers with
// the active-low event output and the shared-pin drivers.
// Assumes a plain register port, synchronous pins, and resetn as global reset.
//
// Summary of operation
// - A change in either socket's power state word sets status bit 7.
// - Changing either socket's voltage request to or from 12 V sets bit 6.
// - Bit 5 of status and enable reads zero; writes are ignored.
// - An input change flag sets on level change only while pin is an input.
// - Status bits 4..0 follow inputs 4..0 on shared pins 5,4,2,1,0.
// - Status, enable and output bits reset only by the global reset.
// - A set enable bit passes its status bit to the event output.
// - Input register bits 4..0 read the current input levels.
// - Input and output register bits 7..5 read zero; writes have no effect.
// - Output register bits 4..0 are read-write and drive outputs 4..0.
// - Routing field 0000 makes a pin an input, 0001 makes it an output.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none

module gpevt_regs (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire gpevt_pkg::gpevt_bus_req_t bus_req,
  output logic      [7:0]                rd_data,
  input  wire gpevt_pkg::gpevt_pwr_req_t pwr_req,
  input  wire gpevt_pkg::gpevt_route_t   route,
  input  wire logic [4:0]                pin_in,
  output logic      [4:0]                pin_out,
  output logic      [4:0]                pin_oe,
  output logic                           event_out_n,
  output logic                           irq
);
  import gpevt_pkg::*;

  logic [7:0]     status_q;
  logic [7:0]     status_d;
  logic [7:0]     enable_q;
  logic [4:0]     output_q;
  logic [4:0]     level_q;
  logic [4:0]     pin_change;
  logic [4:0]     is_input;
  logic [7:0]     set_vec;
  logic [7:0]     clr_vec;
  logic           wr_status;
  logic           wr_enable;
  logic           wr_output;
  logic           power_evt;
  logic           high_vpp_evt;
  logic           pwr_primed_q;
  gpevt_pwr_req_t pwr_prev_q;

  assign wr_status = bus_req.wr && (bus_req.addr == ADDR_STATUS);
  assign wr_enable = bus_req.wr && (bus_req.addr == ADDR_ENABLE);
  assign wr_output = bus_req.wr && (bus_req.addr == ADDR_OUTPUT);

  // Pins routed as general inputs; lines 4..0 sit on shared pins 5,4,2,1,0.
  assign is_input = gpevt_route_match(route, ROUTE_INPUT);

  gpevt_pin_mon u_pin_mon (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pin_in),
    .is_input (is_input),
    .level_q  (level_q),
    .change   (pin_change)
  );

  // Previous power request words; the first sample after reset only loads them.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwr_prev_q <= '0;
    end else begin
      pwr_prev_q <= pwr_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwr_primed_q <= 1'b0;
    end else begin
      pwr_primed_q <= 1'b1;
    end
  end

  assign power_evt = pwr_primed_q &&
                     ((pwr_req.state_a != pwr_prev_q.state_a) ||
                      (pwr_req.state_b != pwr_prev_q.state_b));
  assign high_vpp_evt = pwr_primed_q &&
                        ((pwr_req.vpp12_a != pwr_prev_q.vpp12_a) ||
                         (pwr_req.vpp12_b != pwr_prev_q.vpp12_b));

  always_comb begin
    set_vec = {power_evt, high_vpp_evt, 1'b0, pin_change};
    clr_vec = wr_status ? bus_req.wdata : 8'h00;
    // A new event beats a clear written in the same cycle.
    status_d = ((status_q & ~clr_vec) | set_vec) & EVENT_MASK;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      enable_q <= ENABLE_RST;
    end else if (wr_enable) begin
      enable_q <= bus_req.wdata & EVENT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_q <= OUTPUT_RST;
    end else if (wr_output) begin
      output_q <= bus_req.wdata[GP_MSB:0];
    end
  end

  // The output enable follows routing with one cycle of lag so every pin
  // output comes from a flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_oe <= OUTPUT_RST;
    end else begin
      pin_oe <= gpevt_route_match(route, ROUTE_OUTPUT);
    end
  end

  assign pin_out = output_q;

  // The event output lags the status bits by one cycle; it is a level, not
  // an edge, so the lag never loses an event.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      event_out_n <= 1'b1;
      irq         <= 1'b0;
    end else begin
      event_out_n <= ~|(status_q & enable_q);
      irq         <= |(status_q & enable_q);
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data <= RDATA_IDLE;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_STATUS: rd_data <= status_q;
        ADDR_ENABLE: rd_data <= enable_q;
        ADDR_INPUT:  rd_data <= {3'h0, level_q};
        ADDR_OUTPUT: rd_data <= {3'h0, output_q};
        default:     rd_data <= RDATA_IDLE;
      endcase
    end else begin
      rd_data <= RDATA_IDLE;
    end
  end

  a_power_flag_set: assert property (
    @(posedge clk) disable iff (!resetn)
    power_evt |=> status_q[BIT_POWER]
  ) else $error("power change did not set its flag");

  a_high_vpp_set: assert property (
    @(posedge clk) disable iff (!resetn)
    $changed(pwr_req.vpp12_a) && pwr_primed_q |=> status_q[BIT_HIGH_VPP]
  ) else $error("12 V request change did not set its flag");

  a_reserved_bit_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    !status_q[BIT_RSVD] && !enable_q[BIT_RSVD]
  ) else $error("reserved event bit is not zero");

  a_input_flag_set: assert property (
    @(posedge clk) disable iff (!resetn)
    (pin_change != 5'h00) |=> ((status_q[GP_MSB:0] & $past(pin_change)) == $past(pin_change))
  ) else $error("input change did not set its flag");

  a_input_flag_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[0]) |-> $past(is_input[0]) && ($past(pin_in[0]) != $past(level_q[0]))
  ) else $error("input flag rose without a change on an input pin");

  a_clear_write_one: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_status && (set_vec == 8'h00) |=> ((status_q & $past(bus_req.wdata)) == 8'h00)
  ) else $error("write of one did not clear the flag");

  a_set_beats_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_status && power_evt |=> status_q[BIT_POWER]
  ) else $error("same-cycle event lost to a clear");

  a_flags_sticky: assert property (
    @(posedge clk) disable iff (!resetn)
    status_q[BIT_POWER] && !wr_status |=> status_q[BIT_POWER]
  ) else $error("flag dropped without a clear");

  a_event_output_low: assert property (
    @(posedge clk) disable iff (!resetn)
    (|(status_q & enable_q)) [*2] |-> !event_out_n && irq
  ) else $error("enabled event not signalled");

  a_event_output_high: assert property (
    @(posedge clk) disable iff (!resetn)
    !(|(status_q & enable_q)) [*2] |-> event_out_n && !irq
  ) else $error("event output low with nothing enabled");

  a_input_read: assert property (
    @(posedge clk) disable iff (!resetn)
    bus_req.rd && (bus_req.addr == ADDR_INPUT) |=> rd_data == {3'h0, $past(pin_in, 2)}
  ) else $error("input register read wrong level");

  a_output_upper_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    bus_req.rd && (bus_req.addr == ADDR_OUTPUT) |=> rd_data[7:5] == 3'h0
  ) else $error("upper output bits not zero");

  a_output_drive: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_output |=> pin_out == $past(bus_req.wdata[GP_MSB:0])
  ) else $error("output pins do not follow the written value");

  a_oe_route: assert property (
    @(posedge clk) disable iff (!resetn)
    resetn |=> pin_oe == {$past(route.pin5) == ROUTE_OUTPUT,
                          $past(route.pin4) == ROUTE_OUTPUT,
                          $past(route.pin2) == ROUTE_OUTPUT,
                          $past(route.pin1) == ROUTE_OUTPUT,
                          $past(route.pin0) == ROUTE_OUTPUT}
  ) else $error("output enable does not follow routing");

  a_read_idle: assert property (
    @(posedge clk) disable iff (!resetn)
    !bus_req.rd |=> rd_data == RDATA_IDLE
  ) else $error("read data outside the answer cycle");

  a_power_state_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $changed(pwr_req.state_a) && pwr_primed_q |=> status_q[BIT_POWER]
  ) else $error("socket A power change did not set its flag");

  a_power_state_b: assert property (
    @(posedge clk) disable iff (!resetn)
    $changed(pwr_req.state_b) && pwr_primed_q |=> status_q[BIT_POWER]
  ) else $error("socket B power change did not set its flag");

  a_high_vpp_b: assert property (
    @(posedge clk) disable iff (!resetn)
    $changed(pwr_req.vpp12_b) && pwr_primed_q |=> status_q[BIT_HIGH_VPP]
  ) else $error("socket B 12 V request change did not set its flag");

  a_power_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[BIT_POWER]) |-> $past(pwr_primed_q) &&
      (($past(pwr_req.state_a) != $past(pwr_req.state_a, 2)) ||
       ($past(pwr_req.state_b) != $past(pwr_req.state_b, 2)))
  ) else $error("power flag rose without a power state change");

  a_high_vpp_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[BIT_HIGH_VPP]) |-> $past(pwr_primed_q) &&
      (($past(pwr_req.vpp12_a) != $past(pwr_req.vpp12_a, 2)) ||
       ($past(pwr_req.vpp12_b) != $past(pwr_req.vpp12_b, 2)))
  ) else $error("12 V flag rose without a request change");

  a_input4_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[GP_MSB]) |-> ($past(route.pin5) == ROUTE_INPUT) &&
      $past(pin_in[GP_MSB] != level_q[GP_MSB])
  ) else $error("flag 4 rose without a change on shared pin 5");

  a_input3_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[3]) |-> ($past(route.pin4) == ROUTE_INPUT) &&
      $past(pin_in[3] != level_q[3])
  ) else $error("flag 3 rose without a change on shared pin 4");

  a_input2_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[2]) |-> ($past(route.pin2) == ROUTE_INPUT) &&
      $past(pin_in[2] != level_q[2])
  ) else $error("flag 2 rose without a change on shared pin 2");

  a_input1_cause: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(status_q[1]) |-> ($past(route.pin1) == ROUTE_INPUT) &&
      $past(pin_in[1] != level_q[1])
  ) else $error("flag 1 rose without a change on shared pin 1");

  a_input_blocked: assert property (
    @(posedge clk) disable iff (!resetn)
    (route.pin0 != ROUTE_INPUT) && !status_q[0] |=> !status_q[0]
  ) else $error("flag set for a pin not routed as input");

  a_enable_write: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_enable |=> enable_q == ($past(bus_req.wdata) & EVENT_MASK)
  ) else $error("enable register did not take the written value");

  a_status_read: assert property (
    @(posedge clk) disable iff (!resetn)
    bus_req.rd && (bus_req.addr == ADDR_STATUS) |=> rd_data == $past(status_q)
  ) else $error("status read returned the wrong value");

  a_clear_zero_keep: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_status && (set_vec == 8'h00) |=> status_q == ($past(status_q) & ~$past(bus_req.wdata))
  ) else $error("clear write changed a flag written with zero");

  a_output_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !wr_output |=> $stable(output_q)
  ) else $error("output register changed without a write");

endmodule : gpevt_regs

`default_nettype wire

// ### gpevt_pin_model.sv
// Far-side model of the five shared general-purpose pins.
// Assumes the bench sets the external levels; a pin the device drives loops back.
`default_nettype none

module gpevt_pin_model (
  input  wire logic [4:0] ext_level,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  output logic      [4:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin shows the device's own level, so its change is not an input event.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpevt_pin_model

`default_nettype wire

// ### testbench.sv
// Self-checking bench for the event and general-purpose I/O register group.
// Assumes the pin model on the shared lines and a 20 MHz clock.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpevt_pkg::*;
  logic           clk = 1'b0;
  logic           resetn = 1'b0;
  gpevt_bus_req_t bus_req = '0;
  gpevt_pwr_req_t pwr_req = '0;
  gpevt_route_t   route = '0;
  logic [4:0]     ext_level = 5'h00;
  logic [4:0]     pin_in;
  logic [4:0]     pin_out;
  logic [4:0]     pin_oe;
  logic [7:0]     rd_data;
  logic           event_out_n;
  logic           irq;
  int             num_errors = 0;
  int             compares = 0;

  always #25 clk = ~clk;

  gpevt_regs dut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
    .pwr_req(pwr_req), .route(route), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .event_out_n(event_out_n), .irq(irq));
  gpevt_pin_model pins (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // Event output pair packed as {irq, event_out_n}.
  task automatic chk_evt(input logic [7:0] exp);
    chk({6'h00, irq, event_out_n}, exp);
  endtask : chk_evt

  task automatic t_reset;
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_ENABLE, 8'h00);
    rd(ADDR_OUTPUT, 8'h00);
    chk({3'h0, pin_oe}, 8'h00);
    chk_evt(8'h01);
  endtask : t_reset

  task automatic t_regs;
    wr(ADDR_OUTPUT, 8'hFF);
    rd(ADDR_OUTPUT, 8'h1F);
    chk({3'h0, pin_out}, 8'h1F);
    wr(ADDR_INPUT, 8'hFF);
    rd(ADDR_INPUT, 8'h00);
    wr(ADDR_ENABLE, 8'hFF);
    rd(ADDR_ENABLE, 8'hDF);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h00);
    rd(8'h8C, 8'h00);
    wr(ADDR_OUTPUT, 8'h00);
  endtask : t_regs

  task automatic t_power;
    pwr_req.state_a <= 4'h3;
    idle(3);
    rd(ADDR_STATUS, 8'h80);
    chk_evt(8'h02);
    wr(ADDR_ENABLE, 8'h7F);
    idle(2);
    chk_evt(8'h01);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS, 8'h00);
    @(posedge clk);
    pwr_req.vpp12_b <= 1'b1;
    idle(3);
    rd(ADDR_STATUS, 8'h40);
    chk_evt(8'h02);
    // The clear and a new power change land on the same edge; the event must win.
    @(posedge clk);
    bus_req <= '{addr: ADDR_STATUS, wdata: 8'hC0, wr: 1'b1, rd: 1'b0};
    pwr_req.state_b <= 4'h5;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h80);
  endtask : t_power

  task automatic t_inputs;
    for (int i = 0; i < 5; i++) begin
      ext_level[i] <= 1'b1;
      idle(3);
      rd(ADDR_STATUS, 8'h01 << i);
      rd(ADDR_INPUT, 8'h1F >> (4 - i));
      wr(ADDR_STATUS, 8'h01 << i);
    end
    wr(ADDR_OUTPUT, 8'h01);
    route.pin0 <= ROUTE_OUTPUT;
    idle(3);
    chk({3'h0, pin_oe}, 8'h01);
    wr(ADDR_OUTPUT, 8'h00);
    ext_level[0] <= 1'b0;
    idle(3);
    rd(ADDR_STATUS, 8'h00);
    // Hand the pin back as an input so the reset check sees no output enable.
    @(posedge clk);
    route.pin0 <= ROUTE_INPUT;
  endtask : t_inputs

  task automatic t_second_reset;
    wr(ADDR_OUTPUT, 8'h1F);
    wr(ADDR_ENABLE, 8'hFF);
    pwr_req.state_a <= 4'h0;
    idle(3);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    idle(2);
    t_reset();
  endtask : t_second_reset

  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    idle(2);
    t_reset();
    t_regs();
    t_power();
    t_inputs();
    t_second_reset();
    report_and_stop();
  end

  // The tests need well under a thousand cycles; this limit only catches a hang.
  initial begin
    #500us;
    num_errors++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
